// ==== logic/sbc_ctrl_pkg.sv ====
// constants and types for the control register slice
// Summary of operation
// RQ1: wake bias field 1:0: 00 none, 01 pull-down, 10 pull-up, 11 auto.
// RQ2: reserved bits always read back as zero.
// RQ3: channel mode fields 4:3 and 1:0: off, wake, receive only, normal.
// RQ4: flash bit set lets channel run above 5MBaud without slew control.
// RQ5: flash bit clear limits channel to 5MBaud with slew control.
// RQ6: fail-safe entry rewrites bus and wake registers so device can wake.
// RQ7: cyclic period codes 000..110 give 10ms to 2s; 111 reserved.
// RQ8: power-on and soft reset clear wake bias, bus and timer registers.
// RQ9: config bit 7 routes ADC input to wake pin (0) or battery sense (1).
// RQ10: config bit 6 clear lets soft reset pull reset output low.
// RQ11: config bit 5 set enables boost shutoff on battery low voltage.
// RQ12: boost field 3:2 selects 6.7V, 8V, 10V or 12V.
// RQ13: regulator field 1:0 selects 5.0V, 3.3V default, 1.8V, 1.2V.
// RQ14: soft reset keeps the regulator field value.
// RQ15: with config pin grounded regulator field ignores writes, reads 01.
// RQ16: 16-bit command: 7-bit address, access bit (1 write), data byte.
// RQ17: reserved bit writes and reserved period code are ignored.
package sbc_ctrl_pkg;
  localparam logic [6:0] ADDR_WAKE_BIAS = 7'h08;
  localparam logic [6:0] ADDR_CAN_PAIR = 7'h0a;
  localparam logic [6:0] ADDR_CYC_WAKE = 7'h0c;
  localparam logic [6:0] ADDR_HW_CFG = 7'h0e;
  localparam logic [7:0] MASK_WAKE_BIAS = 8'h03;
  localparam logic [7:0] MASK_CAN_PAIR = 8'hdb;
  localparam logic [7:0] MASK_CYC_WAKE = 8'h07;
  localparam logic [7:0] MASK_HW_CFG = 8'hef;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [1:0] RST_EXT_LEVEL = 2'h1;
  localparam logic [2:0] CYC_RESERVED = 3'h7;
  localparam logic [1:0] FS_WAKE_BIAS = 2'h3;
  localparam logic [1:0] FS_CAN_MODE = 2'h1;
  localparam int CMD_ACCESS_BIT = 7;
  localparam int CMD_DATA_LSB = 8;
  localparam int FLASH2_BIT = 7;
  localparam int FLASH1_BIT = 6;
  localparam int CH2_LSB = 3;
  localparam int CH1_LSB = 0;
  localparam int ADC_SEL_BIT = 7;
  localparam int SRST_PIN_BIT = 6;
  localparam int BOOST_OFF_BIT = 5;
  localparam int BOOST_LSB = 2;
  localparam int EXT_LSB = 0;
  localparam logic [4:0] CMD_BITS = 5'h10;
  typedef enum logic [1:0] {
    BIAS_NONE = 2'b00,
    BIAS_PULL_DOWN = 2'b01,
    BIAS_PULL_UP = 2'b10,
    BIAS_AUTO = 2'b11
  } wake_bias_t;
  typedef enum logic [1:0] {
    CH_OFF = 2'b00,
    CH_WAKE = 2'b01,
    CH_RX_ONLY = 2'b10,
    CH_NORMAL = 2'b11
  } ch_mode_t;
endpackage : sbc_ctrl_pkg

// ==== logic/sbc_cmd_if.sv ====
`timescale 1ns/100ps
// decoded serial command between shifter and register bank
interface sbc_cmd_if;
  logic valid;
  logic write;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport shifter (output valid, output write, output addr, output wdata,
    input rdata);
  modport bank (input valid, input write, input addr, input wdata,
    output rdata);
endinterface : sbc_cmd_if

// ==== logic/sbc_spi_shifter.sv ====
`timescale 1ns/100ps
// 16-bit serial frame shifter, pins sampled through two flops
module sbc_spi_shifter
  import sbc_ctrl_pkg::*;
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic spi_clk_i,
  input wire logic spi_csn_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  sbc_cmd_if.shifter cmd
);
  typedef struct packed {
    logic [2:0] clk_s1;
    logic [2:0] clk_s2;
    logic clk_d;
    logic [15:0] shreg;
    logic [15:0] outreg;
    logic [4:0] count;
    logic valid;
    logic write;
    logic [6:0] addr;
    logic [7:0] wdata;
  } shift_state_t;
  shift_state_t st;
  shift_state_t next_st;
  logic rise;
  logic fall;
  logic csn;
  always_comb begin
    next_st = st;
    next_st.clk_s1 = {spi_clk_i, spi_csn_i, spi_mosi_i};
    next_st.clk_s2 = st.clk_s1;
    next_st.clk_d = st.clk_s2[2];
    next_st.valid = 1'b0;
    csn = st.clk_s2[1];
    rise = st.clk_s2[2] & ~st.clk_d & ~csn;
    fall = ~st.clk_s2[2] & st.clk_d & ~csn;
    if (csn) begin
      next_st.count = 5'h00;
    end else if (rise) begin
      next_st.shreg = {st.shreg[14:0], st.clk_s2[0]};
      next_st.count = st.count + 5'h01;
      if (st.count == CMD_BITS - 5'h01) begin
        // address is sent first, most significant bit first
        next_st.valid = 1'b1;
        next_st.addr = {st.shreg[14:8]};
        next_st.write = st.shreg[CMD_ACCESS_BIT]; // RQ16
        next_st.wdata = {st.shreg[6:0], st.clk_s2[0]}; // RQ16
      end
    end
    if (st.count == 5'h00 && csn) begin
      next_st.outreg = {8'h00, cmd.rdata};
    end else if (fall) begin
      next_st.outreg = {st.outreg[14:0], 1'b0};
    end
  end
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign cmd.valid = st.valid;
  assign cmd.write = st.write;
  assign cmd.addr = st.addr;
  assign cmd.wdata = st.wdata;
  assign spi_miso_o = st.outreg[15];
endmodule : sbc_spi_shifter

// ==== logic/sbc_control_register_slice.sv ====
`timescale 1ns/100ps
// control register slice: wake bias, bus modes, cyclic timer, hw config
module sbc_control_register_slice
  import sbc_ctrl_pkg::*;
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic spi_clk_i,
  input wire logic spi_csn_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  input wire logic soft_reset_i,
  input wire logic fail_safe_entry_i,
  input wire logic power_config_pin_i,
  input wire logic battery_low_i,
  output logic [1:0] wake_pin_bias_sel_o,
  output logic [1:0] bus_ch1_mode_o,
  output logic [1:0] bus_ch2_mode_o,
  output logic bus_ch1_fast_o,
  output logic bus_ch2_fast_o,
  output logic bus_ch1_slew_ctrl_o,
  output logic bus_ch2_slew_ctrl_o,
  output logic [2:0] cyclic_wake_period_o,
  output logic adc_battery_sel_o,
  output logic reset_output_pin_low_o,
  output logic boost_off_o,
  output logic [1:0] boost_level_sel_o,
  output logic [1:0] ext_regulator_level_sel_o
);
  typedef struct packed {
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic fs_d;
    logic [7:0] wake_pin_bias_ctrl;
    logic [7:0] can_pair_mode_ctrl;
    logic [7:0] cyclic_wake_period_ctrl;
    logic [7:0] hardware_config_ctrl;
    logic rst_low;
    logic srst_d;
    logic boost_off;
  } bank_state_t;
  bank_state_t st;
  bank_state_t next_st;
  sbc_cmd_if cmd ();
  logic power_config_pin_gnd;
  logic batt_low;
  logic srst;
  logic fs_rise;
  sbc_spi_shifter u_shifter (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .spi_clk_i(spi_clk_i),
    .spi_csn_i(spi_csn_i),
    .spi_mosi_i(spi_mosi_i),
    .spi_miso_o(spi_miso_o),
    .cmd(cmd.shifter)
  );
  // effective regulator field, forced when config pin is grounded
  function automatic logic [7:0] hw_view(input logic [7:0] r,
                                         input logic gnd);
    logic [7:0] v;
    v = r & MASK_HW_CFG; // RQ2
    if (gnd) begin
      v[EXT_LSB +: 2] = RST_EXT_LEVEL; // RQ15
    end
    return v;
  endfunction : hw_view
  always_comb begin
    power_config_pin_gnd = ~st.pin_s2[0];
    batt_low = st.pin_s2[1];
    srst = st.pin_s2[2];
    fs_rise = fail_safe_entry_i & ~st.fs_d;
    case (cmd.addr)
      ADDR_WAKE_BIAS: cmd.rdata = st.wake_pin_bias_ctrl & MASK_WAKE_BIAS;
      ADDR_CAN_PAIR: cmd.rdata = st.can_pair_mode_ctrl & MASK_CAN_PAIR;
      ADDR_CYC_WAKE: cmd.rdata = st.cyclic_wake_period_ctrl & MASK_CYC_WAKE;
      ADDR_HW_CFG: cmd.rdata = hw_view(st.hardware_config_ctrl, power_config_pin_gnd);
      default: cmd.rdata = RST_ZERO; // RQ2
    endcase
  end
  always_comb begin
    next_st = st;
    next_st.pin_s1 = {soft_reset_i, battery_low_i, power_config_pin_i};
    next_st.pin_s2 = st.pin_s1;
    next_st.fs_d = fail_safe_entry_i;
    if (cmd.valid && cmd.write) begin // RQ16
      case (cmd.addr)
        ADDR_WAKE_BIAS: begin
          next_st.wake_pin_bias_ctrl = cmd.wdata & MASK_WAKE_BIAS; // RQ1
        end
        ADDR_CAN_PAIR: begin
          next_st.can_pair_mode_ctrl = cmd.wdata & MASK_CAN_PAIR; // RQ17
        end
        ADDR_CYC_WAKE: begin
          if (cmd.wdata[2:0] != CYC_RESERVED) begin // RQ17
            next_st.cyclic_wake_period_ctrl = cmd.wdata & MASK_CYC_WAKE;
          end
        end
        ADDR_HW_CFG: begin
          next_st.hardware_config_ctrl[7:2] = cmd.wdata[7:2] &
            MASK_HW_CFG[7:2];
          if (!power_config_pin_gnd && !srst) begin
            next_st.hardware_config_ctrl[1:0] = cmd.wdata[1:0]; // RQ15
          end
        end
        default: begin
        end
      endcase
    end
    if (fs_rise) begin
      // leave channels wake capable and the wake pin biased
      next_st.can_pair_mode_ctrl[CH1_LSB +: 2] = FS_CAN_MODE; // RQ6
      next_st.can_pair_mode_ctrl[CH2_LSB +: 2] = FS_CAN_MODE; // RQ6
      next_st.wake_pin_bias_ctrl[1:0] = FS_WAKE_BIAS; // RQ6
    end
    next_st.srst_d = srst;
    // decide at soft reset onset, the clear below drops bit 6 a cycle later
    if (st.srst_d) begin
      next_st.rst_low = srst & st.rst_low;
    end else begin
      next_st.rst_low = srst & ~st.hardware_config_ctrl[SRST_PIN_BIT]; // RQ10
    end
    next_st.boost_off = batt_low &
      st.hardware_config_ctrl[BOOST_OFF_BIT]; // RQ11
    if (srst) begin
      next_st.wake_pin_bias_ctrl = RST_ZERO; // RQ8
      next_st.can_pair_mode_ctrl = RST_ZERO; // RQ8
      next_st.cyclic_wake_period_ctrl = RST_ZERO; // RQ8
      next_st.hardware_config_ctrl[7:2] = RST_ZERO[7:2]; // RQ14
    end
  end
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '0; // RQ8
      st.hardware_config_ctrl <= {6'h00, RST_EXT_LEVEL}; // RQ13
    end else begin
      st <= next_st;
    end
  end
  assign wake_pin_bias_sel_o = st.wake_pin_bias_ctrl[1:0]; // RQ1
  assign bus_ch1_mode_o = st.can_pair_mode_ctrl[CH1_LSB +: 2]; // RQ3
  assign bus_ch2_mode_o = st.can_pair_mode_ctrl[CH2_LSB +: 2]; // RQ3
  assign bus_ch1_fast_o = st.can_pair_mode_ctrl[FLASH1_BIT]; // RQ4
  assign bus_ch2_fast_o = st.can_pair_mode_ctrl[FLASH2_BIT]; // RQ4
  assign bus_ch1_slew_ctrl_o = ~st.can_pair_mode_ctrl[FLASH1_BIT]; // RQ5
  assign bus_ch2_slew_ctrl_o = ~st.can_pair_mode_ctrl[FLASH2_BIT]; // RQ5
  assign cyclic_wake_period_o = st.cyclic_wake_period_ctrl[2:0]; // RQ7
  assign adc_battery_sel_o = st.hardware_config_ctrl[ADC_SEL_BIT]; // RQ9
  assign reset_output_pin_low_o = st.rst_low;
  assign boost_off_o = st.boost_off;
  assign boost_level_sel_o = st.hardware_config_ctrl[BOOST_LSB +: 2]; // RQ12
  assign ext_regulator_level_sel_o =
    power_config_pin_gnd ? RST_EXT_LEVEL : st.hardware_config_ctrl[EXT_LSB +: 2]; // RQ13
endmodule : sbc_control_register_slice

// ==== sim/spi_host_model.sv ====
// serial host model that clocks 16-bit frames into the slice
`timescale 1ns/100ps
module spi_host_model (
  input wire logic clock_i,
  input wire logic miso_i,
  output logic sclk_o,
  output logic csn_o,
  output logic mosi_o
);
  initial begin
    sclk_o = 1'b0;
    csn_o = 1'b1;
    mosi_o = 1'b0;
  end
  // each serial clock phase lasts four system clocks
  task automatic xfer(input logic [15:0] cmd, output logic [7:0] rd);
    logic [15:0] sh;
    sh = 16'h0000;
    @(negedge clock_i);
    csn_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi_o = cmd[i];
      repeat (4) @(negedge clock_i);
      sclk_o = 1'b1;
      sh = {sh[14:0], miso_i};
      repeat (4) @(negedge clock_i);
      sclk_o = 1'b0;
    end
    repeat (4) @(negedge clock_i);
    csn_o = 1'b1;
    // released line must not keep showing the last bit
    mosi_o = ~mosi_o;
    repeat (4) @(negedge clock_i);
    rd = sh[7:0];
  endtask : xfer
endmodule : spi_host_model

// ==== sim/sbc_ctrl_properties.sv ====
// port assertions for the control register slice
`timescale 1ns/100ps
module sbc_ctrl_properties (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic soft_reset_i,
  input wire logic fail_safe_entry_i,
  input wire logic power_config_pin_i,
  input wire logic battery_low_i,
  input wire logic [1:0] wake_pin_bias_sel_o,
  input wire logic [1:0] bus_ch1_mode_o,
  input wire logic [1:0] bus_ch2_mode_o,
  input wire logic bus_ch1_fast_o,
  input wire logic bus_ch1_slew_ctrl_o,
  input wire logic [2:0] cyclic_wake_period_o,
  input wire logic reset_output_pin_low_o,
  input wire logic boost_off_o,
  input wire logic [1:0] ext_regulator_level_sel_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  sequence quiet_s; !soft_reset_i [*5]; endsequence
  sequence held_s; soft_reset_i [*5]; endsequence
  slew_follow_a: assert property (
    bus_ch1_slew_ctrl_o == !bus_ch1_fast_o) else $error("slew mismatch");
  fail_safe_a: assert property (
    quiet_s ##0 $rose(fail_safe_entry_i) |-> ##[1:3]
    (wake_pin_bias_sel_o == 2'h3 && bus_ch1_mode_o == 2'h1 &&
    bus_ch2_mode_o == 2'h1)) else $error("fail-safe values");
  soft_clear_a: assert property (held_s |->
    wake_pin_bias_sel_o == 2'h0 && bus_ch1_mode_o == 2'h0 &&
    bus_ch2_mode_o == 2'h0 && cyclic_wake_period_o == 3'h0)
    else $error("soft reset clear");
  reset_pin_a: assert property (
    quiet_s |-> !reset_output_pin_low_o) else $error("reset pin low");
  boost_off_a: assert property (
    !battery_low_i [*5] |-> !boost_off_o) else $error("boost off");
  level_lock_a: assert property (
    !power_config_pin_i [*5] |-> ext_regulator_level_sel_o == 2'h1)
    else $error("regulator lock");
  level_kept_a: assert property (
    (soft_reset_i && power_config_pin_i) [*5] |=>
    $stable(ext_regulator_level_sel_o)) else $error("regulator kept");
  period_code_a: assert property (
    cyclic_wake_period_o != 3'h7) else $error("reserved period");
endmodule : sbc_ctrl_properties
bind sbc_control_register_slice sbc_ctrl_properties chk (
  .clock_i(clock_i), .nrst_i(nrst_i), .soft_reset_i(soft_reset_i),
  .fail_safe_entry_i(fail_safe_entry_i),
  .power_config_pin_i(power_config_pin_i), .battery_low_i(battery_low_i),
  .wake_pin_bias_sel_o(wake_pin_bias_sel_o),
  .bus_ch1_mode_o(bus_ch1_mode_o), .bus_ch2_mode_o(bus_ch2_mode_o),
  .bus_ch1_fast_o(bus_ch1_fast_o),
  .bus_ch1_slew_ctrl_o(bus_ch1_slew_ctrl_o),
  .cyclic_wake_period_o(cyclic_wake_period_o),
  .reset_output_pin_low_o(reset_output_pin_low_o),
  .boost_off_o(boost_off_o),
  .ext_regulator_level_sel_o(ext_regulator_level_sel_o));

// ==== sim/testbench.sv ====
// self-checking bench for the control register slice
`timescale 1ns/100ps
module testbench;
  import sbc_ctrl_pkg::*;
  logic clock_i, nrst_i, sck, csn, mosi, miso, srst, fse, power_config_pin, blow;
  logic [1:0] wake, m1, m2, boost, ext, c;
  logic f1, f2, s1, s2, adc, rlow, boff;
  logic [2:0] per;
  logic [7:0] rv, d;
  logic [6:0] ad [4] = '{ADDR_WAKE_BIAS, ADDR_CAN_PAIR, ADDR_CYC_WAKE,
    ADDR_HW_CFG};
  logic [7:0] mk [4] = '{MASK_WAKE_BIAS, MASK_CAN_PAIR, MASK_CYC_WAKE,
    MASK_HW_CFG};
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  sbc_control_register_slice uut (.clock_i(clock_i), .nrst_i(nrst_i),
    .spi_clk_i(sck), .spi_csn_i(csn), .spi_mosi_i(mosi), .spi_miso_o(miso),
    .soft_reset_i(srst), .fail_safe_entry_i(fse), .power_config_pin_i(power_config_pin),
    .battery_low_i(blow), .wake_pin_bias_sel_o(wake), .bus_ch1_mode_o(m1),
    .bus_ch2_mode_o(m2), .bus_ch1_fast_o(f1), .bus_ch2_fast_o(f2),
    .bus_ch1_slew_ctrl_o(s1), .bus_ch2_slew_ctrl_o(s2),
    .cyclic_wake_period_o(per), .adc_battery_sel_o(adc),
    .reset_output_pin_low_o(rlow), .boost_off_o(boff),
    .boost_level_sel_o(boost), .ext_regulator_level_sel_o(ext));
  spi_host_model host (.clock_i(clock_i), .miso_i(miso), .sclk_o(sck),
    .csn_o(csn), .mosi_o(mosi));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %0t got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    host.xfer({a, 1'b1, v}, rv);
    repeat (6) @(negedge clock_i);
  endtask : wr
  // read data comes back in the frame after the addressing one
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    host.xfer({a, 1'b0, 8'h00}, rv);
    host.xfer({a, 1'b0, 8'h00}, rv);
    check(rv, exp);
  endtask : rd
  task automatic conclude;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      errors++;
      conclude();
    end
  end
  initial begin
    {nrst_i, srst, fse, power_config_pin, blow} = 5'h02;
    repeat (5) @(negedge clock_i);
    nrst_i = 1'b1;
    repeat (4) @(negedge clock_i);
    foreach (ad[i]) rd(ad[i], (i == 3) ? 8'h01 : 8'h00);
    foreach (ad[i]) begin
      wr(ad[i], 8'hff);
      rd(ad[i], (i == 2) ? 8'h00 : mk[i]);
    end
    rd(7'h09, 8'h00);
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      d = {c[0], ~c[0], 1'b0, c, 1'b0, c};
      wr(ADDR_WAKE_BIAS, {6'h0, c});
      check({6'h0, wake}, {6'h0, c});
      wr(ADDR_CAN_PAIR, d);
      check({f2, f1, 1'b0, m2, 1'b0, m1}, d);
      check({s2, s1, 6'h0}, {~d[7:6], 6'h0});
      wr(ADDR_HW_CFG, {c[0], 3'h0, c, ~c});
      check({adc, 3'h0, boost, ext}, {c[0], 3'h0, c, ~c});
    end
    for (int j = 0; j < 8; j++) begin
      wr(ADDR_CYC_WAKE, j[7:0]);
      check({5'h0, per}, (j == 7) ? 8'h06 : j[7:0]);
    end
    power_config_pin = 1'b0;
    wr(ADDR_HW_CFG, 8'h03);
    check({6'h0, ext}, 8'h01);
    rd(ADDR_HW_CFG, 8'h01);
    power_config_pin = 1'b1;
    wr(ADDR_HW_CFG, 8'h22);
    blow = 1'b1;
    repeat (6) @(negedge clock_i);
    check({7'h0, boff}, 8'h01);
    wr(ADDR_HW_CFG, 8'h02);
    check({7'h0, boff}, 8'h00);
    blow = 1'b0;
    wr(ADDR_WAKE_BIAS, 8'h03);
    srst = 1'b1;
    repeat (8) @(negedge clock_i);
    check({rlow, 1'b0, wake, 2'h0, ext}, 8'h82);
    srst = 1'b0;
    repeat (6) @(negedge clock_i);
    rd(ADDR_HW_CFG, 8'h02);
    wr(ADDR_HW_CFG, 8'h42);
    srst = 1'b1;
    repeat (8) @(negedge clock_i);
    check({7'h0, rlow}, 8'h00);
    srst = 1'b0;
    repeat (8) @(negedge clock_i);
    fse = 1'b1;
    repeat (3) @(negedge clock_i);
    check({wake, m2, m1, 2'h0}, 8'hd4);
    fse = 1'b0;
    conclude();
  end
endmodule : testbench
